// >>> hdl/otpdac_pkg.sv
// package: constants for the otp program and dac latch block
package otpdac_pkg;
	localparam int OTPDAC_CHANNELS = 20;
	localparam int OTPDAC_DATA_W = 10;
	localparam logic [4:0] OTPDAC_CODE_LAST_DAC = 5'h13;
	localparam logic [4:0] OTPDAC_CODE_WPROT = 5'h14;
	localparam logic [2:0] OTPDAC_SEL_TOP_ZERO = 3'h0;
	localparam logic [1:0] OTPDAC_OTP_MARKER = 2'h1;
	localparam int OTPDAC_BIT_XFER = 7;
	localparam logic [9:0] OTPDAC_MIDSCALE = 10'h200;
	localparam logic [9:0] OTPDAC_OTP_RESET = 10'h000;
	localparam logic [6:0] OTPDAC_DEV_ADDR_DEFAULT = 7'h74; // arbitrary default device address
	typedef enum logic [2:0] {OTPDAC_IDLE, OTPDAC_ADDR, OTPDAC_SEL, OTPDAC_HI, OTPDAC_LO, OTPDAC_IGNORE} otpdac_state_e;
endpackage : otpdac_pkg

// >>> hdl/otpdac_core.sv
// design: two-wire slave that programs otp words and latches dac channels
`timescale 1ns/10ps
// Functional notes
// - otp write is a bus write; device acks its address with r/w low
// - channel select byte: top three bits zero, ack only codes 0 to 20
// - codes map in order, first gamma to second common voltage, twenty outputs
// - at code 20 only data bit 0 counts; it is the write protect flag
// - otp word commits only after its second data byte is received
// - every data byte of an otp write up to the word at code 19 or 20 is acknowledged
// - stop or restart before both bytes abandons the word unchanged
// - programming an otp word also loads dac register and output
// - multi-word writes advance the code after each word; marker each word
// - auto increment never reaches code 20; protect only written directly
// - trailing partial word of a multi-word write is discarded
// - once protect bit is set, all later otp programming is refused
// - otp bits only go from 0 to 1 while programming is enabled
// - dac writes go to a first stage bank; outputs stay steady
// - transfer to outputs on load pin or a word with bit 15 set
// - software transfer updates all channels on that word's final bit
// - at power up channels load otp word, unprogrammed ones midscale
module otpdac_core
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic output_load_pin_n,
	input wire logic [6:0] dev_addr,
	output logic [otpdac_pkg::OTPDAC_CHANNELS*otpdac_pkg::OTPDAC_DATA_W-1:0] dac_out,
	output logic write_protect,
	output logic [4:0] channel_sel,
	output logic otp_prog_pulse
);
	import otpdac_pkg::*;

	// ----------------------------------------
	// bus condition detection
	// ----------------------------------------
	logic scl_reg, sda_reg;
	otpdac_state_e state_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic ack_phase_reg;
	logic ack_drive_reg;
	logic [7:0] hi_byte_reg;
	logic [4:0] code_reg;
	logic multi_reg;
	logic [9:0] otp_mem [0:OTPDAC_CHANNELS-1];
	logic [9:0] stage_mem [0:OTPDAC_CHANNELS-1];
	logic [9:0] out_mem [0:OTPDAC_CHANNELS-1];
	logic wprot_reg;
	logic boot_reg;
	logic [4:0] boot_idx_reg;

	// advance channel code, never past the last dac channel
	function automatic logic [4:0] otpdac_next_code(input logic [4:0] code);
		otpdac_next_code = (code >= OTPDAC_CODE_LAST_DAC) ? OTPDAC_CODE_LAST_DAC : code + 5'h1;
	endfunction : otpdac_next_code

	// true when the select byte names a valid channel
	function automatic logic otpdac_valid_sel(input logic [7:0] sel);
		otpdac_valid_sel = (sel[7:5] == OTPDAC_SEL_TOP_ZERO) && (sel[4:0] <= OTPDAC_CODE_WPROT);
	endfunction : otpdac_valid_sel

	wire scl_rise = scl_in & ~scl_reg;
	wire scl_fall = ~scl_in & scl_reg;
	wire start_cond = scl_in & scl_reg & sda_reg & ~sda_in;
	wire stop_cond = scl_in & scl_reg & ~sda_reg & sda_in;
	wire byte_done = scl_rise & ~ack_phase_reg & (bit_cnt_reg == 4'h7);
	wire [7:0] byte_val = {shift_reg[6:0], sda_in};
	wire is_otp = hi_byte_reg[7:6] == OTPDAC_OTP_MARKER;
	wire word_done = byte_done & (state_reg == OTPDAC_LO);

	// line sample for edge detection
	// resets to the idle high level so leaving reset shows no false edge
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			scl_reg <= 1'b1;
			sda_reg <= 1'b1;
		end
		else
		begin
			scl_reg <= scl_in;
			sda_reg <= sda_in;
		end
	end

	// ----------------------------------------
	// bit and byte framing
	// ----------------------------------------
	// any start or stop realigns the bit count to the next byte
	always_ff @(posedge sys_clk)
	begin
		if (reset || start_cond || stop_cond)
		begin
			bit_cnt_reg <= 4'h0;
			ack_phase_reg <= 1'b0;
			shift_reg <= 8'h00;
		end
		else if (scl_rise)
		begin
			if (ack_phase_reg)
			begin
				ack_phase_reg <= 1'b0;
				bit_cnt_reg <= 4'h0;
			end
			else
			begin
				shift_reg <= byte_val;
				if (bit_cnt_reg == 4'h7)
					ack_phase_reg <= 1'b1;
				else
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
			end
		end
	end

	// ----------------------------------------
	// transaction state
	// ----------------------------------------
	// abandon on stop
	always_ff @(posedge sys_clk)
	begin
		if (reset || stop_cond)
		begin
			state_reg <= OTPDAC_IDLE;
			code_reg <= 5'h00;
			multi_reg <= 1'b0;
			hi_byte_reg <= 8'h00;
		end
		else if (start_cond)
			state_reg <= OTPDAC_ADDR;
		else if (byte_done)
		begin
			case (state_reg)
				OTPDAC_ADDR:
				begin
					// only write transfers are served; a read request goes unanswered
					// address write
					if (byte_val[7:1] == dev_addr && !sda_in)
						state_reg <= OTPDAC_SEL;
					else
						state_reg <= OTPDAC_IGNORE;
				end
				OTPDAC_SEL:
				begin
					if (otpdac_valid_sel(byte_val))
					begin
						code_reg <= byte_val[4:0];
						multi_reg <= 1'b0;
						state_reg <= OTPDAC_HI;
					end
					else
						state_reg <= OTPDAC_IGNORE;
				end
				OTPDAC_HI:
				begin
					hi_byte_reg <= byte_val;
					state_reg <= OTPDAC_LO;
				end
				OTPDAC_LO:
				begin
					if (code_reg == OTPDAC_CODE_WPROT || (multi_reg && code_reg == OTPDAC_CODE_LAST_DAC))
						state_reg <= OTPDAC_IGNORE;
					else
					begin
						code_reg <= otpdac_next_code(code_reg);
						multi_reg <= 1'b1;
						state_reg <= (code_reg == OTPDAC_CODE_LAST_DAC) ? OTPDAC_IGNORE : OTPDAC_HI;
					end
				end
				default: state_reg <= OTPDAC_IGNORE;
			endcase
		end
	end

	// ----------------------------------------
	// acknowledge drive
	// ----------------------------------------
	// ack each accepted byte
	always_ff @(posedge sys_clk)
	begin
		if (reset || start_cond || stop_cond)
			ack_drive_reg <= 1'b0;
		else if (byte_done)
		begin
			case (state_reg)
				OTPDAC_ADDR: ack_drive_reg <= (byte_val[7:1] == dev_addr) && !sda_in;
				OTPDAC_SEL: ack_drive_reg <= otpdac_valid_sel(byte_val);
				OTPDAC_HI: ack_drive_reg <= 1'b1;
				OTPDAC_LO: ack_drive_reg <= 1'b1;
				default: ack_drive_reg <= 1'b0;
			endcase
		end
		else if (scl_fall && !ack_phase_reg)
			ack_drive_reg <= 1'b0;
	end

	// sda is driven low only during the ack slot
	// the pin is only ever pulled low, never driven high
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			sda_oe <= 1'b0;
			sda_out <= 1'b1;
		end
		else
		begin
			if (scl_fall)
				sda_oe <= ack_drive_reg & ack_phase_reg;
			sda_out <= 1'b0;
		end
	end

	// ----------------------------------------
	// otp array, staging bank and outputs
	// ----------------------------------------
	// strobes decoded from a finished word
	wire otp_commit = word_done & is_otp & ~wprot_reg;
	wire [9:0] word_val = {hi_byte_reg[1:0], byte_val};
	wire dac_commit = word_done & (code_reg != OTPDAC_CODE_WPROT);
	wire sw_xfer = word_done & hi_byte_reg[OTPDAC_BIT_XFER];

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			wprot_reg <= 1'b0;
			for (int i = 0; i < OTPDAC_CHANNELS; i++)
				otp_mem[i] <= OTPDAC_OTP_RESET;
		end
		else if (otp_commit)
		begin
			if (code_reg == OTPDAC_CODE_WPROT)
				wprot_reg <= wprot_reg | byte_val[0];
			else
				otp_mem[code_reg] <= otp_mem[code_reg] | word_val;
		end
	end

	// boot walk loads each channel from otp after reset release
	// the bus must stay quiet until the walk has passed every channel
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			boot_reg <= 1'b1;
			boot_idx_reg <= 5'h00;
		end
		else if (boot_reg)
		begin
			boot_idx_reg <= boot_idx_reg + 5'h1;
			if (boot_idx_reg == OTPDAC_CODE_LAST_DAC)
				boot_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			for (int i = 0; i < OTPDAC_CHANNELS; i++)
				stage_mem[i] <= OTPDAC_MIDSCALE;
		end
		else if (boot_reg)
			stage_mem[boot_idx_reg] <= (otp_mem[boot_idx_reg] == OTPDAC_OTP_RESET) ?
				OTPDAC_MIDSCALE : otp_mem[boot_idx_reg];
		else if (dac_commit)
			stage_mem[code_reg] <= otp_commit ? (otp_mem[code_reg] | word_val) : word_val;
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			for (int i = 0; i < OTPDAC_CHANNELS; i++)
				out_mem[i] <= OTPDAC_MIDSCALE;
		end
		else if (boot_reg)
			out_mem[boot_idx_reg] <= (otp_mem[boot_idx_reg] == OTPDAC_OTP_RESET) ?
				OTPDAC_MIDSCALE : otp_mem[boot_idx_reg];
		else
		begin
			for (int i = 0; i < OTPDAC_CHANNELS; i++)
			begin
				if (!output_load_pin_n || sw_xfer)
					out_mem[i] <= (dac_commit && code_reg == 5'(i)) ? stage_next(i) : stage_mem[i];
				else if (otp_commit && code_reg == 5'(i))
					out_mem[i] <= otp_mem[i] | word_val;
			end
		end
	end

	// value the staging bank takes this cycle for a channel
	function automatic logic [9:0] stage_next(input int idx);
		stage_next = otp_commit ? (otp_mem[idx] | word_val) : word_val;
	endfunction : stage_next

	// ----------------------------------------
	// registered outputs
	// ----------------------------------------
	// protect flag visible
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			dac_out <= '0;
			write_protect <= 1'b0;
			channel_sel <= 5'h00;
			otp_prog_pulse <= 1'b0;
		end
		else
		begin
			for (int i = 0; i < OTPDAC_CHANNELS; i++)
				dac_out[i*OTPDAC_DATA_W +: OTPDAC_DATA_W] <= out_mem[i];
			write_protect <= wprot_reg;
			channel_sel <= code_reg;
			otp_prog_pulse <= otp_commit;
		end
	end
endmodule : otpdac_core

// >>> tb/otpdac_core_sva.sv
// checker: port level properties of the otp program and dac latch core
`timescale 1ns/10ps
module otpdac_core_sva
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic output_load_pin_n,
	input wire logic [6:0] dev_addr,
	input wire logic [otpdac_pkg::OTPDAC_CHANNELS*otpdac_pkg::OTPDAC_DATA_W-1:0] dac_out,
	input wire logic write_protect,
	input wire logic [4:0] channel_sel,
	input wire logic otp_prog_pulse
);
	import otpdac_pkg::*;
	logic [5:0] boot_cnt_reg;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	// counts cycles since reset so the boot walk is skipped
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			boot_cnt_reg <= 6'h00;
		else if (boot_cnt_reg != 6'h3f)
			boot_cnt_reg <= boot_cnt_reg + 6'h01;
	end
	property p_ack_low;
		sda_oe |-> !sda_out;
	endproperty
	a_ack_low: assert property (p_ack_low) else $error("ack slot drives high");
	property p_oe_scl;
		$rose(sda_oe) |-> !scl_in;
	endproperty
	a_oe_scl: assert property (p_oe_scl) else $error("ack starts with clock high");
	property p_oe_hold;
		$rose(sda_oe) |-> sda_oe [*4];
	endproperty
	a_oe_hold: assert property (p_oe_hold) else $error("ack too short");
	property p_pulse;
		otp_prog_pulse |=> !otp_prog_pulse;
	endproperty
	a_pulse: assert property (p_pulse) else $error("commit pulse too long");
	property p_wp_keep;
		write_protect |=> write_protect;
	endproperty
	a_wp_keep: assert property (p_wp_keep) else $error("protect flag cleared");
	property p_wp_sel;
		$rose(write_protect) |-> channel_sel == OTPDAC_CODE_WPROT;
	endproperty
	a_wp_sel: assert property (p_wp_sel) else $error("protect set from wrong code");
	property p_no_prog;
		$past(write_protect, 3) |-> !otp_prog_pulse;
	endproperty
	a_no_prog: assert property (p_no_prog) else $error("commit while protected");
	property p_dac_still;
		boot_cnt_reg == 6'h3f && !$stable(dac_out) |-> $past(scl_in) || !$past(output_load_pin_n)
			|| !$past(output_load_pin_n, 2) || !$past(output_load_pin_n, 3);
	endproperty
	a_dac_still: assert property (p_dac_still) else $error("outputs moved without cause");
endmodule : otpdac_core_sva
bind otpdac_core otpdac_core_sva i_otpdac_core_sva (.sys_clk(sys_clk), .reset(reset), .scl_in(scl_in),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .output_load_pin_n(output_load_pin_n),
	.dev_addr(dev_addr), .dac_out(dac_out), .write_protect(write_protect), .channel_sel(channel_sel),
	.otp_prog_pulse(otp_prog_pulse));

// >>> tb/otpdac_master.sv
// partner: two-wire bus master driving the serial link of the core
`timescale 1ns/10ps
module otpdac_master
(
	input wire logic sys_clk,
	output logic scl = 1'b1,
	output logic sda_low = 1'b0,
	input wire logic sda
);
	localparam int HALF = 6;
	// waits one half bit period
	task automatic half;
		repeat (HALF) @(posedge sys_clk);
	endtask : half
	// one clock pulse on the link
	task automatic pulse;
		half();
		scl <= 1'b1;
		half();
		scl <= 1'b0;
	endtask : pulse
	// start, also usable as a repeated start
	task automatic start;
		sda_low <= 1'b0;
		half();
		scl <= 1'b1;
		half();
		sda_low <= 1'b1;
		half();
		scl <= 1'b0;
	endtask : start
	// stop, link left idle with clock high
	task automatic stop;
		sda_low <= 1'b1;
		half();
		scl <= 1'b1;
		half();
		sda_low <= 1'b0;
		half();
	endtask : stop
	// byte out msb first, ack read at end of ninth clock
	task automatic wbyte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--)
		begin
			sda_low <= !b[i];
			pulse();
		end
		sda_low <= 1'b0;
		half();
		scl <= 1'b1;
		half();
		ack = !sda;
		scl <= 1'b0;
	endtask : wbyte
endmodule : otpdac_master

// >>> tb/otp_program_and_dac_latch_test.sv
// testbench: otp programming, write protect and output latch of the core
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module otp_program_and_dac_latch_test;
	import otpdac_pkg::*;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic output_load_pin_n = 1'b1;
	logic scl;
	logic sda_low;
	logic sda_out;
	logic sda_oe;
	logic write_protect;
	logic otp_prog_pulse;
	logic [4:0] channel_sel;
	logic [OTPDAC_CHANNELS*OTPDAC_DATA_W-1:0] dac_out;
	int n_mismatch = 0;
	int num_checks = 0;
	int n_pulse = 0;
	int p0;
	// open-drain data line with a pull-up
	wire sda = !(sda_low || (sda_oe && !sda_out));
	always #2.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (otp_prog_pulse === 1'b1) n_pulse++;
	otpdac_core i_otpdac_core (.sys_clk(sys_clk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .output_load_pin_n(output_load_pin_n), .dev_addr(OTPDAC_DEV_ADDR_DEFAULT),
		.dac_out(dac_out), .write_protect(write_protect), .channel_sel(channel_sel), .otp_prog_pulse(otp_prog_pulse));
	otpdac_master i_otpdac_master (.sys_clk(sys_clk), .scl(scl), .sda_low(sda_low), .sda(sda));
	function automatic logic [9:0] ch(input int i);
		return dac_out[i*OTPDAC_DATA_W +: OTPDAC_DATA_W];
	endfunction : ch
	task automatic sb(input logic [7:0] b, input logic exp);
		logic a;
		i_otpdac_master.wbyte(b, a);
		`CHK(a, exp)
	endtask : sb
	task automatic open(input logic [4:0] sel);
		i_otpdac_master.start();
		sb({OTPDAC_DEV_ADDR_DEFAULT, 1'b0}, 1'b1);
		sb({OTPDAC_SEL_TOP_ZERO, sel}, 1'b1);
	endtask : open
	task automatic word(input logic [15:0] w);
		sb(w[15:8], 1'b1);
		sb(w[7:0], 1'b1);
	endtask : word
	task automatic close;
		i_otpdac_master.stop();
		repeat (4) @(posedge sys_clk);
	endtask : close
	task automatic tally_and_finish;
		if (n_mismatch == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : tally_and_finish
	// single word, then a second word or-ed into it
	task automatic t_single;
		for (int i = 0; i < OTPDAC_CHANNELS; i++)
			`CHK(ch(i), OTPDAC_MIDSCALE)
		open(5'h03);
		word(16'h42a5);
		close();
		`CHK(ch(3), 10'h2a5)
		`CHK(n_pulse, 1)
		open(5'h03);
		word(16'h400f);
		close();
		`CHK(ch(3), 10'h2af)
	endtask : t_single
	// auto increment, trailing partial word, no step onto the protect code
	task automatic t_multi;
		logic a;
		open(5'h11);
		word(16'h4111);
		word(16'h4222);
		sb(8'h43, 1'b1);
		close();
		`CHK(ch(17), 10'h111)
		`CHK(ch(18), 10'h222)
		`CHK(ch(19), OTPDAC_MIDSCALE)
		open(5'h13);
		word(16'h4333);
		i_otpdac_master.wbyte(8'h40, a);
		i_otpdac_master.wbyte(8'h01, a);
		close();
		`CHK(ch(19), 10'h333)
		`CHK(write_protect, 1'b0)
	endtask : t_multi
	// abandoned word, wrong address, bad select codes
	task automatic t_refuse;
		open(5'h05);
		sb(8'h41, 1'b1);
		i_otpdac_master.start();
		sb({OTPDAC_DEV_ADDR_DEFAULT ^ 7'h01, 1'b0}, 1'b0);
		open(5'h00);
		i_otpdac_master.start();
		sb({OTPDAC_DEV_ADDR_DEFAULT, 1'b0}, 1'b1);
		sb(8'h15, 1'b0);
		i_otpdac_master.start();
		sb({OTPDAC_DEV_ADDR_DEFAULT, 1'b0}, 1'b1);
		sb(8'h25, 1'b0);
		close();
		`CHK(ch(5), OTPDAC_MIDSCALE)
	endtask : t_refuse
	// staging writes, software trigger, load pin transfer
	task automatic t_latch;
		open(5'h00);
		word(16'h0155);
		close();
		`CHK(ch(0), OTPDAC_MIDSCALE)
		open(5'h01);
		word(16'h8066);
		close();
		`CHK(ch(0), 10'h155)
		`CHK(ch(1), 10'h066)
		open(5'h02);
		word(16'h0077);
		close();
		`CHK(ch(2), OTPDAC_MIDSCALE)
		output_load_pin_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		output_load_pin_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		`CHK(ch(2), 10'h077)
		// batch whose eighteenth gamma word carries the trigger
		open(5'h10);
		word(16'h0044);
		word(16'h8055);
		close();
		`CHK(ch(16), 10'h044)
		`CHK(ch(17), 10'h055)
	endtask : t_latch
	// protect flag only from bit 0, then programming refused
	task automatic t_protect;
		open(OTPDAC_CODE_WPROT);
		word(16'h43fe);
		close();
		`CHK(write_protect, 1'b0)
		open(OTPDAC_CODE_WPROT);
		word(16'h4001);
		close();
		`CHK(write_protect, 1'b1)
		p0 = n_pulse;
		open(5'h06);
		word(16'h4100);
		close();
		`CHK(n_pulse, p0)
		open(5'h03);
		word(16'h8123);
		close();
		`CHK(ch(3), 10'h123)
	endtask : t_protect
	initial
	begin
		repeat (30000) @(posedge sys_clk);
		n_mismatch++;
		tally_and_finish();
	end
	initial
	begin
		repeat (16) @(posedge sys_clk);
		reset <= 1'b0;
		repeat (30) @(posedge sys_clk);
		t_single();
		t_multi();
		t_refuse();
		t_latch();
		t_protect();
		tally_and_finish();
	end
endmodule : otp_program_and_dac_latch_test
